// ===== design/config_word_decode_and_id.sv
// Configuration word decode, identification and regulator hold-off
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cfg_decode_regs.svh"
module config_word_decode_and_id
  import cfg_decode_pkg::*;
#(
  parameter logic [7:0] FAMILY_ID = 8'ha5, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h3c, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value
  parameter logic [6:0] LAST_PAGE = `LAST_PAGE_FULL,
  parameter int SETTLE_CYCLES = `REG_SETTLE_CYCLES
)
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [23:0] cfgWordThree, // Stored config word three
  input wire logic [23:0] cfgWordFour, // Stored config word four
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic sleepEnter, // Pulse: core enters sleep
  input wire logic wakeEvent, // Pulse: wake from sleep
  input wire logic [6:0] flashPage, // Page of a flash write
  output logic flashPageProtected, // That page is write protected
  output logic cfgPageLocked, // Config page is protected
  input wire logic twowire1ClockOut, // Port 1 clock drive low
  input wire logic twowire1DataOut, // Port 1 data drive low
  output logic twowire1PrimaryClockOe, // Primary clock pin enable
  output logic twowire1PrimaryDataOe, // Primary data pin enable
  output logic twowire1AltClockOe, // Alternate clock pin enable
  output logic twowire1AltDataOe, // Alternate data pin enable
  output mult_mode_t clockMultMode, // Decoded multiplier mode
  output logic clockMultEnable, // Multiplier running
  output logic deepSleepActive, // Deep sleep entered
  output logic dsWatchdogRun, // Deep-sleep watchdog running
  output logic dsWatchdogUseLprc, // Watchdog clock is low-power RC
  output logic [5:0] dsWatchdogDivLog2, // Divide ratio as power of two
  output logic brownoutEnable, // Brown-out reset active
  output logic regulatorStandby, // Regulator in standby
  output logic cpuRun, // Code execution allowed
  output logic remapWriteAllowed // Remap registers writable
);
  // ------------------------------------------------------------
  // Latched configuration
  // ------------------------------------------------------------
  logic [23:0] cw3Ff;
  logic [23:0] cw4Ff;
  logic loadedFf;

  // Capture words while in reset, hold them afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      cw3Ff <= cfgWordThree | `CW3_HELD_HIGH_MASK;
      cw4Ff <= cfgWordFour | `CW4_HELD_HIGH_MASK;
      loadedFf <= 1'b0;
    end else begin
      loadedFf <= 1'b1;
    end
  end

  logic protectEnd;
  logic cfgPageProtect;
  logic protectDisable;
  logic [6:0] boundaryPage;
  logic oneWay;
  logic [3:0] multCode;
  logic dsSwControl;
  logic dsWdtEnable;
  logic dsBorEnable;

  assign protectEnd = cw3Ff[`CW3_PROTECT_END_BIT];
  assign cfgPageProtect = cw3Ff[`CW3_CFG_PAGE_PROTECT_BIT];
  assign protectDisable = cw3Ff[`CW3_PROTECT_DISABLE_BIT];
  assign boundaryPage = cw3Ff[`CW3_BOUNDARY_MSB:0];
  assign oneWay = cw4Ff[`CW4_ONE_WAY_BIT];
  assign multCode = cw4Ff[`CW4_MULT_MSB:`CW4_MULT_LSB];
  assign dsSwControl = cw4Ff[`CW4_DS_SW_CONTROL_BIT];
  assign dsWdtEnable = cw4Ff[`CW4_DS_WDT_ENABLE_BIT];
  assign dsBorEnable = cw4Ff[`CW4_DS_BOR_ENABLE_BIT];

  // ------------------------------------------------------------
  // Segment protection
  // ------------------------------------------------------------
  protect_range u_protect (
    .pageAddr(flashPage),
    .boundaryPage(boundaryPage),
    .lastPage(LAST_PAGE),
    .protectEnd(protectEnd),
    .cfgPageProtect(cfgPageProtect),
    .protectDisable(protectDisable),
    .pageProtected(flashPageProtected),
    .cfgPageLocked(cfgPageLocked)
  );

  // ------------------------------------------------------------
  // Two-wire pin routing
  // ------------------------------------------------------------
  logic primaryLoc;
  assign primaryLoc = cw4Ff[`CW4_TWOWIRE_LOC_BIT];

  // Open-drain enables steered to one pin pair
  always_comb begin
    twowire1PrimaryClockOe = primaryLoc && twowire1ClockOut;
    twowire1PrimaryDataOe = primaryLoc && twowire1DataOut;
    twowire1AltClockOe = !primaryLoc && twowire1ClockOut;
    twowire1AltDataOe = !primaryLoc && twowire1DataOut;
  end

  // ------------------------------------------------------------
  // Clock multiplier decode
  // ------------------------------------------------------------
  always_comb begin
    case (multCode)
      `MULT_OFF: clockMultMode = MULT_NONE;
      `MULT_X8: clockMultMode = MULT_TIMES8;
      `MULT_X6: clockMultMode = MULT_TIMES6;
      `MULT_X4: clockMultMode = MULT_TIMES4;
      default: clockMultMode = MULT_RESERVED;
    endcase
  end
  assign clockMultEnable = (clockMultMode == MULT_TIMES4) ||
    (clockMultMode == MULT_TIMES6) || (clockMultMode == MULT_TIMES8);

  // ------------------------------------------------------------
  // Deep-sleep watchdog settings
  // ------------------------------------------------------------
  assign dsWatchdogUseLprc = cw4Ff[`CW4_DS_WDT_CLOCK_BIT];
  // Code 0 divides by 2^5, each step doubles
  assign dsWatchdogDivLog2 = 6'h05 +
    {1'b0, cw4Ff[`CW4_POSTSCALE_MSB:0]};

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [1:0] pwrCtlFf;
  logic remapLockFf;
  logic lockEverSetFf;
  logic [1:0] unlockStepFf;
  logic wbReq;
  logic wbWr;
  logic ackFf;
  logic settleBusy;
  pwr_state_t stateFf;

  assign wbReq = wb_cyc_i && wb_stb_i && !ackFf;
  assign wbWr = wbReq && wb_we_i && wb_sel_i[0];

  // Acknowledge every request one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      ackFf <= 1'b0;
    end else begin
      ackFf <= wbReq;
    end
  end
  assign wb_ack_o = ackFf;

  // Power control: regulator standby and deep-sleep request
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrCtlFf <= `PWR_CONTROL_RESET;
    end else if (wbWr && wb_adr_i == `OFS_POWER_CONTROL) begin
      pwrCtlFf <= wb_dat_i[1:0];
    end
  end

  // Unlock sequence: two key writes, then one lock write
  always_ff @(posedge clk) begin
    if (rst) begin
      unlockStepFf <= 2'h0;
    end else if (wbWr && wb_adr_i == `OFS_REMAP_CONTROL) begin
      if (wb_dat_i[15:8] == `UNLOCK_KEY_ONE) begin
        unlockStepFf <= 2'h1;
      end else if (wb_dat_i[15:8] == `UNLOCK_KEY_TWO &&
        unlockStepFf == 2'h1) begin
        unlockStepFf <= 2'h2;
      end else begin
        unlockStepFf <= 2'h0;
      end
    end else if (wbWr) begin
      unlockStepFf <= 2'h0;
    end
  end

  logic lockWrite;
  assign lockWrite = wbWr && wb_adr_i == `OFS_REMAP_CONTROL &&
    wb_dat_i[15:8] == 8'h00 && unlockStepFf == 2'h2;

  // Remap lock bit
  always_ff @(posedge clk) begin
    if (rst) begin
      remapLockFf <= 1'b0;
      lockEverSetFf <= 1'b0;
    end else if (lockWrite) begin
      if (oneWay) begin
        if (!lockEverSetFf && wb_dat_i[`REMAP_LOCK_BIT]) begin
          remapLockFf <= 1'b1;
          lockEverSetFf <= 1'b1;
        end
      end else begin
        remapLockFf <= wb_dat_i[`REMAP_LOCK_BIT];
      end
    end
  end
  assign remapWriteAllowed = !remapLockFf;

  // Read mux
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbReq && !wb_we_i) begin
      if (wb_adr_i == `OFS_CONFIG_WORD_THREE) begin
        wb_dat_o <= {8'h00, cw3Ff};
      end else if (wb_adr_i == `OFS_CONFIG_WORD_FOUR) begin
        wb_dat_o <= {8'h00, cw4Ff};
      end else if (wb_adr_i == `OFS_PART_IDENTIFICATION) begin
        wb_dat_o <= {8'h00, 8'hff, FAMILY_ID, PART_ID};
      end else if (wb_adr_i == `OFS_SILICON_REVISION) begin
        wb_dat_o <= {28'h0000000, REVISION};
      end else if (wb_adr_i == `OFS_POWER_CONTROL) begin
        wb_dat_o <= {30'h0, pwrCtlFf};
      end else if (wb_adr_i == `OFS_REMAP_CONTROL) begin
        wb_dat_o <= {30'h0, unlockStepFf == 2'h2, remapLockFf};
      end else if (wb_adr_i == `OFS_STATUS) begin
        wb_dat_o <= {27'h0, deepSleepActive, regulatorStandby,
          settleBusy, cpuRun, dsWatchdogRun};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Power state and regulator settling
  // ------------------------------------------------------------
  logic settleStart;
  logic dsAllowed;
  assign dsAllowed = dsSwControl && pwrCtlFf[`PWR_DS_REQUEST_BIT];

  // Settling starts on release of reset and on every wake
  assign settleStart = (stateFf == PWR_LOAD && loadedFf) ||
    (stateFf == PWR_SLEEP && wakeEvent);

  settle_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk(clk),
    .rst(rst),
    .start(settleStart),
    .busy(settleBusy)
  );

  logic dsFf;
  logic standbyFf;
  logic sleepEntry;
  logic wakeEntry;

  // Sleep entry and wake as honoured by the sequencer
  assign sleepEntry = (stateFf == PWR_RUN) && sleepEnter;
  assign wakeEntry = (stateFf == PWR_SLEEP) && wakeEvent;

  // Run, sleep, settle sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      stateFf <= PWR_LOAD;
    end else begin
      case (stateFf)
        PWR_LOAD: begin
          if (loadedFf) begin
            stateFf <= PWR_SETTLE;
          end
        end
        PWR_RUN: begin
          if (sleepEnter) begin
            stateFf <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (wakeEvent) begin
            stateFf <= PWR_SETTLE;
          end
        end
        PWR_SETTLE: begin
          if (!settleBusy) begin
            stateFf <= PWR_RUN;
          end
        end
        default: stateFf <= PWR_LOAD;
      endcase
    end
  end

  // Deep-sleep flag: taken at sleep entry, dropped on wake
  always_ff @(posedge clk) begin
    if (rst) begin
      dsFf <= 1'b0;
    end else if (sleepEntry) begin
      dsFf <= dsAllowed;
    end else if (wakeEntry) begin
      dsFf <= 1'b0;
    end
  end

  // Regulator standby only when its control bit is clear
  always_ff @(posedge clk) begin
    if (rst) begin
      standbyFf <= 1'b0;
    end else if (sleepEntry) begin
      standbyFf <= !pwrCtlFf[`PWR_REG_STANDBY_BIT];
    end else if (wakeEntry) begin
      standbyFf <= 1'b0;
    end
  end

  assign cpuRun = (stateFf == PWR_RUN);
  assign deepSleepActive = dsFf;
  assign regulatorStandby = standbyFf;
  assign dsWatchdogRun = dsWdtEnable && dsFf;
  assign brownoutEnable = !dsFf || dsBorEnable;
endmodule

// ===== design/cfg_decode_regs.svh
// Offsets, field positions, reset values and timing counts for config decode
`ifndef CFG_DECODE_REGS_SVH
`define CFG_DECODE_REGS_SVH

// Register byte offsets on the bus
`define OFS_CONFIG_WORD_THREE 8'h00
`define OFS_CONFIG_WORD_FOUR 8'h04
`define OFS_PART_IDENTIFICATION 8'h08
`define OFS_SILICON_REVISION 8'h0c
`define OFS_POWER_CONTROL 8'h10
`define OFS_REMAP_CONTROL 8'h14
`define OFS_STATUS 8'h18

// Word three fields
`define CW3_PROTECT_END_BIT 15
`define CW3_CFG_PAGE_PROTECT_BIT 14
`define CW3_PROTECT_DISABLE_BIT 13
`define CW3_BOUNDARY_MSB 6
`define CW3_HELD_HIGH_MASK 24'hff0080

// Word four fields
`define CW4_ONE_WAY_BIT 15
`define CW4_TWOWIRE_LOC_BIT 14
`define CW4_MULT_MSB 13
`define CW4_MULT_LSB 10
`define CW4_DS_SW_CONTROL_BIT 8
`define CW4_DS_WDT_ENABLE_BIT 7
`define CW4_DS_BOR_ENABLE_BIT 6
`define CW4_DS_WDT_CLOCK_BIT 5
`define CW4_POSTSCALE_MSB 4
`define CW4_HELD_HIGH_MASK 24'hff0200

// Multiplier codes
`define MULT_OFF 4'hf
`define MULT_X8 4'he
`define MULT_X6 4'hd
`define MULT_X4 4'hc

// Power control bits and reset value
`define PWR_REG_STANDBY_BIT 0
`define PWR_DS_REQUEST_BIT 1
`define PWR_CONTROL_RESET 2'h1

// Remap control: lock bit and unlock key sequence
`define REMAP_LOCK_BIT 0
`define UNLOCK_KEY_ONE 8'h46
`define UNLOCK_KEY_TWO 8'h57

// Pages and regulator settling
`define PAGE_WORDS 512
`define LAST_PAGE_FULL 7'h7f
`define REG_SETTLE_NS 10000
`define REG_SETTLE_CYCLES ((`REG_SETTLE_NS + 4) / 5)

`endif

// ===== design/cfg_decode_pkg.sv
// Types shared by the configuration decode block
package cfg_decode_pkg;
  typedef enum logic [2:0] {
    MULT_NONE,
    MULT_TIMES4,
    MULT_TIMES6,
    MULT_TIMES8,
    MULT_RESERVED
  } mult_mode_t;

  typedef enum logic [1:0] {
    PWR_LOAD,
    PWR_RUN,
    PWR_SLEEP,
    PWR_SETTLE
  } pwr_state_t;
endpackage

// ===== design/protect_range.sv
// Segment write protection check for one program-memory page
`timescale 1ns/1ps
module protect_range
  import cfg_decode_pkg::*;
(
  input wire logic [6:0] pageAddr, // Page of the write or erase
  input wire logic [6:0] boundaryPage, // Boundary page field
  input wire logic [6:0] lastPage, // Last implemented page
  input wire logic protectEnd, // Protect-end select
  input wire logic cfgPageProtect, // Config page protect, active low
  input wire logic protectDisable, // Segment protect disable
  output logic pageProtected, // Page is write protected
  output logic cfgPageLocked // Config page is protected
);
  logic inSegment;

  // Segment limits from the end select
  always_comb begin
    if (protectEnd) begin
      inSegment = (pageAddr >= boundaryPage);
    end else begin
      inSegment = (pageAddr <= boundaryPage);
    end
  end

  // Config page forced protected by end select, its own protect bit (low) or boundary match
  always_comb begin
    cfgPageLocked = !protectDisable && (protectEnd || !cfgPageProtect ||
      boundaryPage == lastPage);
  end

  // Overall protection only while the segment is enabled
  always_comb begin
    pageProtected = !protectDisable && (inSegment ||
      (pageAddr == lastPage && cfgPageLocked));
  end
endmodule

// ===== design/settle_timer.sv
// Regulator settling counter that holds off execution
`timescale 1ns/1ps
`include "cfg_decode_regs.svh"
module settle_timer
  import cfg_decode_pkg::*;
#(
  parameter int SETTLE_CYCLES = `REG_SETTLE_CYCLES
)
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic start, // Begin a settling interval
  output logic busy // Interval still running
);
  logic [15:0] countFf;

  // Load on start, count down to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      countFf <= 16'h0000;
    end else if (start) begin
      countFf <= 16'(SETTLE_CYCLES);
    end else if (countFf != 16'h0000) begin
      countFf <= countFf - 16'h0001;
    end
  end

  assign busy = start || (countFf != 16'h0000);
endmodule

// ===== test/config_word_decode_and_id_props.sv
// Concurrent checks on the configuration decode block ports
`timescale 1ns/1ps
module config_word_decode_and_id_props
  import cfg_decode_pkg::*;
#(
  parameter int SETTLE_CYCLES = 8
)
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [23:0] cfgWordThree, // Config word three
  input wire logic [23:0] cfgWordFour, // Config word four
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Bus address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic flashPageProtected, // Page protected
  input wire logic twowire1ClockOut, // Port clock pull
  input wire logic twowire1PrimaryClockOe, // Primary clock enable
  input wire logic twowire1AltClockOe, // Alternate clock enable
  input wire mult_mode_t clockMultMode, // Multiplier mode
  input wire logic clockMultEnable, // Multiplier on
  input wire logic deepSleepActive, // Deep sleep
  input wire logic dsWatchdogRun, // Watchdog running
  input wire logic dsWatchdogUseLprc, // Watchdog clock select
  input wire logic [5:0] dsWatchdogDivLog2, // Divide exponent
  input wire logic brownoutEnable, // Brown-out active
  input wire logic cpuRun, // Execution allowed
  input wire logic remapWriteAllowed // Remap writable
);
  logic [23:0] wordThreeFf, wordFourFf;
  logic [15:0] lowCountFf;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Copy of the words captured while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      wordThreeFf <= cfgWordThree;
      wordFourFf <= cfgWordFour;
    end
  end

  // Cycles spent with execution held
  always_ff @(posedge clk) begin
    if (rst || cpuRun) begin
      lowCountFf <= 16'h0000;
    end else if (lowCountFf != 16'hffff) begin
      lowCountFf <= lowCountFf + 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ack_follows_req_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rev_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c |-> wb_dat_o[31:4] == 28'h0)
    else $error("revision upper bits not zero");
  mult_off_a: assert property (
    wordFourFf[13:10] == 4'hf |->
      clockMultMode == MULT_NONE && !clockMultEnable)
    else $error("multiplier not off");
  mult_x8_a: assert property (
    wordFourFf[13:10] == 4'he |->
      clockMultMode == MULT_TIMES8 && clockMultEnable)
    else $error("multiplier not times eight");
  port_route_a: assert property (
    wordFourFf[14] |-> !twowire1AltClockOe
      && twowire1PrimaryClockOe == twowire1ClockOut)
    else $error("port not on primary pins");
  wdt_clock_a: assert property (dsWatchdogUseLprc == wordFourFf[5])
    else $error("watchdog clock select wrong");
  post_scale_a: assert property (
    dsWatchdogDivLog2 == {1'b0, wordFourFf[4:0]} + 6'h05)
    else $error("postscaler exponent wrong");
  wdt_off_a: assert property (!wordFourFf[7] |-> !dsWatchdogRun)
    else $error("watchdog runs while disabled");
  ds_gate_a: assert property (!wordFourFf[8] |-> !deepSleepActive)
    else $error("deep sleep while unavailable");
  bor_deep_a: assert property (
    deepSleepActive && !wordFourFf[6] |-> !brownoutEnable)
    else $error("brown-out active in deep sleep");
  lock_sticky_a: assert property (
    wordFourFf[15] && !remapWriteAllowed |=> !remapWriteAllowed)
    else $error("one-way lock released");
  protect_off_a: assert property (
    wordThreeFf[13] |-> !flashPageProtected)
    else $error("page protected while disabled");
  settle_hold_a: assert property (
    $rose(cpuRun) |-> lowCountFf >= SETTLE_CYCLES)
    else $error("execution resumed before settling");
endmodule

bind config_word_decode_and_id config_word_decode_and_id_props #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_props (
  .clk, .rst, .cfgWordThree, .cfgWordFour, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .flashPageProtected,
  .twowire1ClockOut, .twowire1PrimaryClockOe, .twowire1AltClockOe,
  .clockMultMode, .clockMultEnable, .deepSleepActive, .dsWatchdogRun,
  .dsWatchdogUseLprc, .dsWatchdogDivLog2, .brownoutEnable, .cpuRun,
  .remapWriteAllowed
);

// ===== test/config_word_decode_and_id_tb_top.sv
// Self-checking bench for the configuration decode block
`timescale 1ns/1ps
module config_word_decode_and_id_tb_top;
  import cfg_decode_pkg::*;
  localparam int SETTLE = 8;
  localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART = 8'hc3; // Arbitrary value
  localparam logic [3:0] REVISION_CODE = 4'h6; // Arbitrary value
  logic clk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, rd;
  logic [23:0] cw3 = 24'hffffff, cw4 = 24'hffffff, m3, m4;
  logic sleepIn = 0, wakeIn = 0, clkOut = 0, datOut = 0;
  logic [6:0] page = 7'h00, p;
  logic protOut, lockedOut, pOeC, pOeD, aOeC, aOeD, multEn, dsAct, wdtRun;
  logic wdtLprc, bor, standby, run, remapOk;
  logic [5:0] divLog;
  mult_mode_t multMode;
  int badCount = 0, numChecks = 0, seed = 32'h026d, n;

  config_word_decode_and_id #(
    .FAMILY_ID(FAM), .PART_ID(PART), .REVISION(REVISION_CODE), .SETTLE_CYCLES(SETTLE)
  ) u_dut (
    .clk(clk), .rst(rst), .cfgWordThree(cw3), .cfgWordFour(cw4),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .sleepEnter(sleepIn), .wakeEvent(wakeIn),
    .flashPage(page), .flashPageProtected(protOut),
    .cfgPageLocked(lockedOut), .twowire1ClockOut(clkOut),
    .twowire1DataOut(datOut), .twowire1PrimaryClockOe(pOeC),
    .twowire1PrimaryDataOe(pOeD), .twowire1AltClockOe(aOeC),
    .twowire1AltDataOe(aOeD), .clockMultMode(multMode),
    .clockMultEnable(multEn), .deepSleepActive(dsAct),
    .dsWatchdogRun(wdtRun), .dsWatchdogUseLprc(wdtLprc),
    .dsWatchdogDivLog2(divLog), .brownoutEnable(bor),
    .regulatorStandby(standby), .cpuRun(run), .remapWriteAllowed(remapOk)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // Model and tasks
  // ----------------------------------------
  // Expected protection of one page
  function automatic logic prot(input logic [23:0] w, input logic [6:0] q);
    if (w[13]) return 1'b0;
    if (w[15]) return q >= w[6:0];
    return q <= w[6:0] ||
      (q == 7'h7f && (!w[14] || w[6:0] == 7'h7f));
  endfunction

  // Expected multiplier mode
  function automatic mult_mode_t multExp(input logic [3:0] c);
    case (c)
      4'hf: return MULT_NONE;
      4'he: return MULT_TIMES8;
      4'hd: return MULT_TIMES6;
      4'hc: return MULT_TIMES4;
      default: return MULT_RESERVED;
    endcase
  endfunction

  task automatic finishTest;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      badCount++;
    end
  endtask

  // One classic bus cycle, held until ack is sampled
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    if (k == 20) begin
      badCount++;
      finishTest();
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  // Count edges until execution is allowed
  task automatic waitRun(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (run !== 1'b1 && k < 60);
    if (k == 60) begin
      badCount++;
      finishTest();
    end
  endtask

  task automatic doReset(input logic [23:0] a, input logic [23:0] b);
    int k;
    rst <= 1'b1;
    cw3 <= a;
    cw4 <= b;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    waitRun(k);
    chk(k >= SETTLE, 1);
  endtask

  // Unlock sequence, then lock value
  task automatic setLock(input logic v);
    wbx(1'b1, 8'h14, 32'h4600);
    wbx(1'b1, 8'h14, 32'h5700);
    wbx(1'b1, 8'h14, {31'h0, v});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      m3 = 24'($random(seed)) | 24'hff0080;
      m4 = 24'($random(seed)) | 24'hff0200;
      m3[13] = (i == 7);
      if (i < 4) m3[6] = 1'b0;
      m4[13:10] = 4'hb + 4'(i % 5);
      doReset(m3, m4);
      {clkOut, datOut} <= 2'($random(seed));
      cw4 <= ~m4;
      @(posedge clk);
      chk(multMode, multExp(m4[13:10]));
      chk(multEn, m4[13:10] inside {4'hc, 4'hd, 4'he});
      chk(divLog, m4[4:0] + 6'h05);
      chk(wdtLprc, m4[5]);
      chk({pOeC, pOeD, aOeC, aOeD},
          m4[14] ? {clkOut, datOut, 2'b00} : {2'b00, clkOut, datOut});
      chk(lockedOut, prot(m3, 7'h7f));
      chk(remapOk, 1);
      for (int j = 0; j < 4; j++) begin
        p = j == 3 ? 7'($random(seed)) : j == 2 ? 7'h7f : m3[6:0] + 7'(j);
        page <= p;
        @(posedge clk);
        chk(protOut, prot(m3, p));
      end
      wbx(1'b0, 8'h00, 32'h0);
      chk(rd, {8'h00, m3});
      wbx(1'b0, 8'h04, 32'h0);
      chk(rd, {8'h00, m4});
      wbx(1'b1, 8'h08, 32'($random(seed)));
      wbx(1'b0, 8'h08, 32'h0);
      chk(rd, {16'h00ff, FAM, PART});
      wbx(1'b0, 8'h0c, 32'h0);
      chk(rd, {28'h0, REVISION_CODE});
      wbx(1'b0, 8'h1c, 32'h0);
      chk(rd, 0);
    end
    // Remap lock, one-way then free
    for (int k = 0; k < 2; k++) begin
      doReset(24'hffffff, k == 0 ? 24'hffffff : 24'hff7fff);
      wbx(1'b1, 8'h14, 32'h1);
      chk(remapOk, 1);
      setLock(1'b1);
      chk(remapOk, 0);
      wbx(1'b0, 8'h14, 32'h0);
      chk(rd[0], 1);
      setLock(1'b0);
      chk(remapOk, k);
    end
    // Sleep entry and wake, deep sleep then plain sleep
    for (int k = 0; k < 2; k++) begin
      doReset(24'hffffff, k == 0 ? 24'hffffbf : 24'hfffeff);
      wbx(1'b1, 8'h10, {30'h0, 1'b1, k[0]});
      sleepIn <= 1'b1;
      @(posedge clk);
      sleepIn <= 1'b0;
      @(posedge clk);
      chk(run, 0);
      chk(dsAct, k == 0);
      chk(standby, k == 0);
      chk(wdtRun, k == 0);
      chk(bor, k == 1);
      wakeIn <= 1'b1;
      @(posedge clk);
      wakeIn <= 1'b0;
      waitRun(n);
      chk(n >= SETTLE, 1);
      chk(standby, 0);
    end
    finishTest();
  end
endmodule
